// ### design/smch_top.sv
/*
 * Command decoder of a micro-stepping motion controller on a two-wire bus.
 * Assumes a byte receiver (on the link clock) delivers bytes with a toggle
 * strobe and frame end as a level; strobe and level are synchronised here, the data byte is not.
 */
`timescale 1ns/1ps
// What this block does
// - Address byte: 11, four fused bits, pin level, then zero.
// - Program frame: address, 0x90, two 0xff, index byte, fuse pattern.
// - Move frame: address, 0x8b, two 0xff, position high then low.
// - Target is relative to zero, in units set by step resolution.
// - Moves are ignored while thermal, undervoltage, lost step or fault set.
// - Gentle halt (address, 0x8f) decelerates to minimum speed then stops.
// - Over-temperature triggers the same gentle halt by itself.
// - First status read clears shutdown; device then accepts motion.
// - Seek started with actual equal to first target deadlocks.
// - After second seek motion, actual position becomes zero.
// - Node address distinguishes up to 32 devices.
// - Fused address bits start at zero until programmed.
// - Electrical fault is coil A fault OR coil B fault.
// - Coil fault set by overcurrent or open load on that coil.
// - Switch input affects no state machine or command.
// - Deadlock left only by abrupt halt then first status read.
module smch_top (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic link_clk,
    input wire logic byte_tgl,
    input wire logic [7:0] byte_data,
    input wire logic frame_active,
    input wire logic hardwired_address_pin,
    input wire logic thermal_shutdown_flag,
    input wire logic undervoltage_flag,
    input wire logic lost_step_flag,
    input wire logic coil_a_overcurrent,
    input wire logic coil_a_open_load,
    input wire logic coil_b_overcurrent,
    input wire logic coil_b_open_load,
    input wire logic [1:0] step_resolution,
    input wire logic seek_second_done,
    input wire logic [15:0] actual_position,
    input wire logic switch_input,
    output logic [15:0] target_position,
    output logic [1:0] target_resolution,
    output logic move_start,
    output logic gentle_halt_cmd,
    output logic abrupt_halt_cmd,
    output logic reference_seek_cmd,
    output logic actual_position_clear,
    output logic otp_program_cmd,
    output logic [2:0] otp_byte_index,
    output logic [7:0] otp_pattern,
    output logic [3:0] fused_node_address,
    output logic shutdown_state,
    output logic deadlock_state,
    output logic coil_a_fault_flag,
    output logic coil_b_fault_flag,
    output logic electrical_fault_flag,
    output logic switch_status_flag,
    output logic frame_dropped
);
    typedef enum logic [2:0] {
        SMCH_IDLE, SMCH_RECV, SMCH_READ, SMCH_EXEC
    } smch_state_t;

    typedef struct packed {
        smch_state_t st;
        logic [2:0] s_tgl;
        logic [1:0] s_act;
        logic [1:0] s_pin;
        logic [1:0] s_sw;
        logic [1:0] s_lck;
        logic [3:0] cnt;
        logic [3:0] rd_idx;
        logic [7:0] op;
        logic [15:0] tpos;
        logic [15:0] pbuf;
        logic [1:0] tres;
        logic move;
        logic ghalt;
        logic ahalt;
        logic seek;
        logic pclr;
        logic otp;
        logic [2:0] oidx;
        logic [7:0] opat;
        logic [3:0] fuse;
        logic shut;
        logic dlock;
        logic halted;
        logic fa;
        logic fb;
        logic ef;
        logic sw;
        logic drop;
        logic tsd_d;
    } smch_reg_t;

    smch_reg_t r_ff, nxt_r;
    logic [7:0] rd_byte;
    logic wr_en;

    // Frame bytes land in the store as each synchronised strobe arrives
    assign wr_en = (r_ff.s_tgl[2] ^ r_ff.s_tgl[1]) && r_ff.s_act[1];

    smch_frame_mem #(.DEPTH(smch_pkg::FRAME_DEPTH)) i_smch_frame_mem (
        .clk_sys(clk_sys),
        .wr_en(wr_en),
        .wr_addr(r_ff.cnt),
        .wr_data(byte_data),
        .rd_addr(r_ff.rd_idx),
        .rd_data(rd_byte)
    );

    // Required frame length per opcode; zero marks an unknown opcode
    function automatic logic [3:0] need_len(input logic [7:0] op);
        case (op)
            smch_pkg::OP_OTP_PROGRAM: need_len = smch_pkg::LEN_SIX;
            smch_pkg::OP_TARGET_MOVE: need_len = smch_pkg::LEN_SIX;
            smch_pkg::OP_GENTLE_HALT: need_len = smch_pkg::LEN_TWO;
            smch_pkg::OP_ABRUPT_HALT: need_len = smch_pkg::LEN_TWO;
            smch_pkg::OP_FULL_STATUS_ONE: need_len = smch_pkg::LEN_TWO;
            smch_pkg::OP_REFERENCE_SEEK: need_len = smch_pkg::LEN_SEEK;
            default: need_len = 4'h0;
        endcase
    endfunction

    always_comb
    begin
        nxt_r = r_ff;
        // Two-stage synchronisers; only the last stages are read.
        // Byte data is assumed stable while the strobe crosses.
        nxt_r.s_tgl = {r_ff.s_tgl[1:0], byte_tgl};
        nxt_r.s_act = {r_ff.s_act[0], frame_active};
        nxt_r.s_pin = {r_ff.s_pin[0], hardwired_address_pin};
        nxt_r.s_sw = {r_ff.s_sw[0], switch_input};
        nxt_r.s_lck = {r_ff.s_lck[0], link_clk};
        nxt_r.move = 1'b0;
        nxt_r.ghalt = 1'b0;
        nxt_r.ahalt = 1'b0;
        nxt_r.seek = 1'b0;
        nxt_r.pclr = 1'b0;
        nxt_r.otp = 1'b0;
        nxt_r.drop = 1'b0;
        nxt_r.tsd_d = thermal_shutdown_flag;
        // Switch level is only mirrored for status reads, nothing uses it
        nxt_r.sw = r_ff.s_sw[1];
        // Coil flags are sticky, set wins; cleared by a first status read
        nxt_r.fa = r_ff.fa | coil_a_overcurrent | coil_a_open_load;
        nxt_r.fb = r_ff.fb | coil_b_overcurrent | coil_b_open_load;
        // Over-temperature rising edge halts gently by itself
        if (thermal_shutdown_flag && !r_ff.tsd_d)
        begin
            nxt_r.ghalt = 1'b1;
            nxt_r.shut = 1'b1;
        end
        if (undervoltage_flag || lost_step_flag || r_ff.ef)
            nxt_r.shut = 1'b1;
        // Second seek motion done: zero the actual position
        if (seek_second_done)
            nxt_r.pclr = 1'b1;
        case (r_ff.st)
            SMCH_IDLE:
            begin
                nxt_r.cnt = 4'h0;
                if (r_ff.s_act[1])
                    nxt_r.st = SMCH_RECV;
            end
            SMCH_RECV:
            begin
                if (wr_en && r_ff.cnt != 4'hf)
                    nxt_r.cnt = r_ff.cnt + 4'h1;
                if (!r_ff.s_act[1] && !wr_en)
                begin
                    nxt_r.rd_idx = 4'h0;
                    nxt_r.st = SMCH_READ;
                end
            end
            SMCH_READ:
            begin
                // Walk the stored bytes; check address then opcode
                nxt_r.rd_idx = r_ff.rd_idx + 4'h1;
                if (r_ff.rd_idx == 4'h1)
                begin
                    // rd_byte holds byte 0 now
                    if (rd_byte[7:6] != smch_pkg::ADDR_TOP
                        || rd_byte[5:2] != r_ff.fuse
                        || rd_byte[1] != r_ff.s_pin[1]
                        || rd_byte[0] != 1'b0)
                    begin
                        nxt_r.drop = 1'b1;
                        nxt_r.st = SMCH_IDLE;
                    end
                end
                else if (r_ff.rd_idx == 4'h2)
                begin
                    nxt_r.op = rd_byte;
                    if (need_len(rd_byte) == 4'h0
                        || r_ff.cnt < need_len(rd_byte))
                    begin
                        nxt_r.drop = 1'b1;
                        nxt_r.st = SMCH_IDLE;
                    end
                end
                else if (r_ff.rd_idx == 4'h3 || r_ff.rd_idx == 4'h4)
                begin
                    if ((r_ff.op == smch_pkg::OP_OTP_PROGRAM
                        || r_ff.op == smch_pkg::OP_TARGET_MOVE)
                        && rd_byte != smch_pkg::FILLER)
                    begin
                        nxt_r.drop = 1'b1;
                        nxt_r.st = SMCH_IDLE;
                    end
                end
                else if (r_ff.rd_idx == 4'h5)
                begin
                    // Staged only; outputs change when the command runs
                    nxt_r.pbuf = {r_ff.pbuf[7:0], rd_byte};
                    if (r_ff.op == smch_pkg::OP_OTP_PROGRAM
                        && rd_byte[7:3] != smch_pkg::OTP_IDX_TOP)
                    begin
                        nxt_r.drop = 1'b1;
                        nxt_r.st = SMCH_IDLE;
                    end
                end
                else if (r_ff.rd_idx == 4'h6 || r_ff.rd_idx == 4'h7)
                begin
                    // Seek shifts once more so bytes 5 and 6 remain
                    nxt_r.pbuf = {r_ff.pbuf[7:0], rd_byte};
                end
                if (r_ff.rd_idx == 4'h2 && nxt_r.st == SMCH_READ
                    && need_len(rd_byte) == smch_pkg::LEN_TWO)
                    nxt_r.st = SMCH_EXEC;
                if (r_ff.rd_idx == 4'h6
                    && r_ff.op != smch_pkg::OP_REFERENCE_SEEK)
                    nxt_r.st = SMCH_EXEC;
                if (r_ff.rd_idx == 4'h7)
                    nxt_r.st = SMCH_EXEC;
            end
            SMCH_EXEC:
            begin
                nxt_r.st = SMCH_IDLE;
                case (r_ff.op)
                    smch_pkg::OP_TARGET_MOVE:
                        // Refused under any shutdown cause or while locked
                        if (!thermal_shutdown_flag && !undervoltage_flag
                            && !lost_step_flag && !r_ff.ef
                            && !r_ff.shut && !r_ff.dlock)
                        begin
                            nxt_r.move = 1'b1;
                            nxt_r.tpos = r_ff.pbuf;
                            nxt_r.tres = step_resolution;
                        end
                    smch_pkg::OP_GENTLE_HALT:
                        nxt_r.ghalt = 1'b1;
                    smch_pkg::OP_ABRUPT_HALT:
                    begin
                        nxt_r.ahalt = 1'b1;
                        nxt_r.halted = 1'b1;
                    end
                    smch_pkg::OP_FULL_STATUS_ONE:
                    begin
                        // Report then leave shutdown; a fault still present sets it again a cycle later
                        nxt_r.shut = 1'b0;
                        nxt_r.fa = coil_a_overcurrent | coil_a_open_load;
                        nxt_r.fb = coil_b_overcurrent | coil_b_open_load;
                        if (r_ff.halted)
                        begin
                            nxt_r.dlock = 1'b0;
                            nxt_r.halted = 1'b0;
                        end
                    end
                    smch_pkg::OP_REFERENCE_SEEK:
                        if (!r_ff.dlock)
                        begin
                            nxt_r.seek = 1'b1;
                            // Byte 5/6 hold first target; equal: locked
                            if (r_ff.pbuf == actual_position)
                                nxt_r.dlock = 1'b1;
                        end
                    smch_pkg::OP_OTP_PROGRAM:
                    begin
                        nxt_r.otp = 1'b1;
                        nxt_r.oidx = r_ff.pbuf[10:8];
                        nxt_r.opat = r_ff.pbuf[7:0];
                        // Fuses only ever go from zero to one
                        if (r_ff.pbuf[10:8] == 3'h2)
                            nxt_r.fuse = r_ff.fuse | r_ff.pbuf[3:0];
                    end
                    default:
                        nxt_r.drop = 1'b1;
                endcase
                // Any command other than another abrupt halt between halt and status read voids the halt
                if (r_ff.op != smch_pkg::OP_ABRUPT_HALT)
                    nxt_r.halted = 1'b0;
            end
            default:
                nxt_r.st = SMCH_IDLE;
        endcase
        // Taken after any clear, so a stale fault cannot re-arm shutdown
        nxt_r.ef = nxt_r.fa | nxt_r.fb;
    end

    // Fresh parts power up with zero fused address, shut down
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            r_ff <= '0;
            r_ff.st <= SMCH_IDLE;
            r_ff.fuse <= 4'h0;
            r_ff.shut <= 1'b1;
        end
        else
            r_ff <= nxt_r;
    end

    assign target_position = r_ff.tpos;
    assign target_resolution = r_ff.tres;
    assign move_start = r_ff.move;
    assign gentle_halt_cmd = r_ff.ghalt;
    assign abrupt_halt_cmd = r_ff.ahalt;
    assign reference_seek_cmd = r_ff.seek;
    assign actual_position_clear = r_ff.pclr;
    assign otp_program_cmd = r_ff.otp;
    assign otp_byte_index = r_ff.oidx;
    assign otp_pattern = r_ff.opat;
    assign fused_node_address = r_ff.fuse;
    assign shutdown_state = r_ff.shut;
    assign deadlock_state = r_ff.dlock;
    assign coil_a_fault_flag = r_ff.fa;
    assign coil_b_fault_flag = r_ff.fb;
    assign electrical_fault_flag = r_ff.ef;
    assign switch_status_flag = r_ff.sw;
    assign frame_dropped = r_ff.drop;
endmodule

// ### shared/smch_pkg.sv
/*
 * Constants for the stepper motion command handler: frame layout, opcodes,
 * frame lengths, node count and frame buffer depth.
 * Assumes it is compiled before the design files that reference it.
 */
package smch_pkg;
    // Address byte layout
    localparam logic [1:0] ADDR_TOP = 2'h3;
    localparam int ADDR_FUSE_LSB = 2;
    localparam int ADDR_PIN_BIT = 1;
    // Opcodes
    localparam logic [7:0] OP_OTP_PROGRAM = 8'h90;
    localparam logic [7:0] OP_TARGET_MOVE = 8'h8b;
    localparam logic [7:0] OP_GENTLE_HALT = 8'h8f;
    localparam logic [7:0] OP_ABRUPT_HALT = 8'h85;
    localparam logic [7:0] OP_FULL_STATUS_ONE = 8'h81;
    localparam logic [7:0] OP_REFERENCE_SEEK = 8'h88;
    localparam logic [7:0] FILLER = 8'hff;
    localparam logic [4:0] OTP_IDX_TOP = 5'h1f;
    // Frame lengths in bytes
    localparam logic [3:0] LEN_SIX = 4'h6;
    localparam logic [3:0] LEN_TWO = 4'h2;
    localparam logic [3:0] LEN_SEEK = 4'h9;
    // Node address range
    localparam int NODE_COUNT = 32;
    // Frame byte buffer depth
    localparam int FRAME_DEPTH = 9;
endpackage

// ### design/smch_frame_mem.sv
/*
 * Small byte store holding the bytes of the frame being received.
 * Assumes one writer and one reader on the system clock; read is registered.
 */
`timescale 1ns/1ps
module smch_frame_mem #(
    parameter int DEPTH = 9
)
(
    input wire logic clk_sys,
    input wire logic wr_en,
    input wire logic [3:0] wr_addr,
    input wire logic [7:0] wr_data,
    input wire logic [3:0] rd_addr,
    output logic [7:0] rd_data
);
    logic [7:0] mem [DEPTH];

    initial
    begin
        if (DEPTH < 9 || DEPTH > 16)
            $error("smch_frame_mem: DEPTH must be 9..16");
    end

    // Storage with registered read, no reset needed for data
    always_ff @(posedge clk_sys)
    begin
        if (wr_en && (int'(wr_addr) < DEPTH))
            mem[wr_addr] <= wr_data;
        rd_data <= (int'(rd_addr) < DEPTH) ? mem[rd_addr] : 8'hff;
    end
endmodule

// ### sim/smch_top_assertions.sv
/* Timing checks on the command handler's ports.
   Assumes one clock domain, clk_sys, with async active-low rst_n. */
`timescale 1ns/1ps
module smch_top_checker (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic thermal_shutdown_flag,
    input wire logic undervoltage_flag,
    input wire logic lost_step_flag,
    input wire logic coil_a_overcurrent,
    input wire logic coil_a_open_load,
    input wire logic coil_b_overcurrent,
    input wire logic coil_b_open_load,
    input wire logic seek_second_done,
    input wire logic [15:0] target_position,
    input wire logic move_start,
    input wire logic gentle_halt_cmd,
    input wire logic actual_position_clear,
    input wire logic otp_program_cmd,
    input wire logic [3:0] fused_node_address,
    input wire logic shutdown_state,
    input wire logic deadlock_state,
    input wire logic coil_a_fault_flag,
    input wire logic coil_b_fault_flag,
    input wire logic electrical_fault_flag,
    input wire logic frame_dropped
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    // Fault summary follows the two coil flags within two cycles
    chk_fault_or: assert property (
        (coil_a_fault_flag || coil_b_fault_flag) |-> ##[0:2]
        electrical_fault_flag) else $error("fault summary missing");
    chk_fault_none: assert property (
        (!(coil_a_fault_flag || coil_b_fault_flag))[*3] |->
        !electrical_fault_flag) else $error("fault summary spurious");
    chk_coil_a_set: assert property (
        (coil_a_overcurrent || coil_a_open_load) |-> ##[0:4]
        coil_a_fault_flag) else $error("coil a flag not set");
    chk_coil_b_set: assert property (
        (coil_b_overcurrent || coil_b_open_load) |-> ##[0:4]
        coil_b_fault_flag) else $error("coil b flag not set");
    // A move may only launch from a healthy, unlocked state
    chk_move_gate: assert property (
        move_start |-> !$past(shutdown_state) && !$past(deadlock_state))
        else $error("move while blocked");
    chk_move_flags: assert property (
        (thermal_shutdown_flag || undervoltage_flag || lost_step_flag ||
        electrical_fault_flag)[*4] |-> !move_start)
        else $error("move while flagged");
    chk_move_pulse: assert property (
        move_start |=> !move_start) else $error("move pulse too long");
    chk_target_hold: assert property (
        $changed(target_position) |-> move_start)
        else $error("target changed without move");
    // Fuses only gain ones, and only from a program command
    chk_fuse_or: assert property (
        $changed(fused_node_address) |-> (otp_program_cmd ||
        $past(otp_program_cmd)) && ((fused_node_address &
        $past(fused_node_address)) == $past(fused_node_address)))
        else $error("fused address changed badly");
    chk_tsd_halt: assert property (
        $rose(thermal_shutdown_flag) |-> ##[1:16] gentle_halt_cmd)
        else $error("no halt on over-temperature");
    chk_seek_clear: assert property (
        seek_second_done |-> ##[1:4] actual_position_clear)
        else $error("position not cleared");
    cov_move: cover property (move_start);
    cov_dead: cover property ($rose(deadlock_state));
    cov_otp: cover property (otp_program_cmd);
    cov_drop: cover property (frame_dropped);
endmodule
bind smch_top smch_top_checker i_smch_top_checker (.*);

// ### sim/smch_master_model.sv
/* Bus master stand-in: sends frames byte by byte to the handler.
   Assumes link_clk runs only inside frames; data is released after. */
`timescale 1ns/1ps
module smch_master_model (
    input wire logic clk_sys,
    output logic link_clk,
    output logic byte_tgl,
    output logic [7:0] byte_data,
    output logic frame_active
);
    initial
    begin
        {link_clk, byte_tgl, frame_active} = 3'h0;
        byte_data = 8'h00;
    end
    // Bytes come first-in-front from a right-aligned frame vector
    task automatic send_frame(input logic [71:0] f, input int n);
        repeat (12) @(posedge clk_sys); // Gap keeps frames apart
        frame_active <= 1'h1;
        for (int i = 0; i < n; i++)
        begin
            repeat (16)
            begin
                repeat (4) @(posedge clk_sys);
                link_clk <= ~link_clk; // 160 ns link period
            end
            byte_data <= f[8*(n-1-i) +: 8];
            byte_tgl <= ~byte_tgl;
        end
        repeat (8) @(posedge clk_sys); // Data stands past the toggle
        frame_active <= 1'h0;
        byte_data <= ~byte_data; // Released line shows no stale value
    endtask
endmodule

// ### sim/tb_smch_top.sv
/* Self-checking bench for the command handler, one task a scenario.
   Assumes the master model and the bound checker are compiled. */
`timescale 1ns/1ps
module tb_smch_top;
    logic clk_sys, rst_n, link_clk, byte_tgl, frame_active;
    logic hardwired_address_pin, thermal_shutdown_flag, undervoltage_flag;
    logic lost_step_flag, coil_a_overcurrent, coil_a_open_load;
    logic coil_b_overcurrent, coil_b_open_load, seek_second_done;
    logic switch_input, move_start, gentle_halt_cmd, abrupt_halt_cmd;
    logic reference_seek_cmd, actual_position_clear, otp_program_cmd;
    logic shutdown_state, deadlock_state, coil_a_fault_flag;
    logic coil_b_fault_flag, electrical_fault_flag, switch_status_flag;
    logic frame_dropped;
    logic [7:0] byte_data, otp_pattern;
    logic [1:0] step_resolution, target_resolution;
    logic [15:0] actual_position, target_position;
    logic [2:0] otp_byte_index;
    logic [3:0] fused_node_address, node;
    logic [6:0] seen;
    int bad_count, checked;
    smch_top i_smch_top (.*);
    smch_master_model i_smch_master_model (.*);
    initial
    begin
        clk_sys = 1'h0;
        forever #10 clk_sys = ~clk_sys;
    end
    task automatic report_and_stop();
        if (bad_count == 0 && checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic chk(input string what, input logic [15:0] exp,
        input logic [15:0] got);
        checked++;
        if (got !== exp)
        begin
            $display("Error %s expected %h seen %h", what, exp, got);
            bad_count++;
        end
    endtask
    function automatic logic [7:0] ab(input int hw);
        return {2'h3, node, hw[0], 1'h0};
    endfunction
    // Pulses are gathered over a window longer than the answer delay
    task automatic grab();
        seen = 7'h00;
        repeat (30)
        begin
            @(negedge clk_sys);
            seen = seen | {move_start, gentle_halt_cmd, abrupt_halt_cmd,
                reference_seek_cmd, actual_position_clear,
                otp_program_cmd, frame_dropped};
        end
    endtask
    task automatic cmd(input int n, input logic [71:0] f);
        i_smch_master_model.send_frame(f, n);
        grab();
    endtask
    task automatic st();
        cmd(2, {ab(0), 8'h81});
    endtask
    task automatic mv(input logic [15:0] p);
        cmd(6, {ab(0), 8'h8b, 16'hffff, p});
    endtask
    task automatic t_gate();
        mv(16'h0102);
        chk("move in shutdown", 16'h0, seen[6]);
        st();
        chk("shutdown", 16'h0, shutdown_state);
        for (int i = 0; i < 4; i++)
        begin
            @(posedge clk_sys);
            {coil_a_overcurrent, lost_step_flag, undervoltage_flag,
                thermal_shutdown_flag} <= 4'h1 << i;
            mv(16'h0203);
            chk("move flagged", 16'h0, seen[6]);
            @(posedge clk_sys);
            {coil_a_overcurrent, lost_step_flag, undervoltage_flag,
                thermal_shutdown_flag} <= 4'h0;
            st();
        end
    endtask
    task automatic t_move();
        @(posedge clk_sys);
        step_resolution <= 2'h2;
        mv(16'h1234);
        chk("pulses", 16'h40, seen);
        chk("target", 16'h1234, target_position);
        chk("resolution", 16'h2, target_resolution);
        @(posedge clk_sys);
        step_resolution <= 2'h1;
        mv(16'hfedc);
        chk("target", 16'hfedc, target_position);
        chk("resolution", 16'h1, target_resolution);
    endtask
    task automatic t_refuse();
        cmd(6, {ab(1), 8'h8b, 16'hffff, 16'h5555});
        chk("wrong node", 16'h1, seen);
        cmd(5, {ab(0), 8'h8b, 16'hffff, 8'h55});
        chk("short frame", 16'h1, seen);
        cmd(2, {ab(0), 8'h8c});
        chk("bad opcode", 16'h1, seen);
        chk("target kept", 16'hfedc, target_position);
    endtask
    task automatic t_halt();
        cmd(2, {ab(0), 8'h8f});
        chk("gentle halt", 16'h20, seen);
        @(posedge clk_sys);
        thermal_shutdown_flag <= 1'h1;
        grab();
        chk("thermal halt", 16'h1, seen[5]);
        @(posedge clk_sys);
        thermal_shutdown_flag <= 1'h0;
        st();
    endtask
    task automatic t_coil();
        @(posedge clk_sys);
        coil_b_open_load <= 1'h1;
        repeat (3) @(posedge clk_sys);
        coil_b_open_load <= 1'h0;
        repeat (4) @(negedge clk_sys);
        chk("coil b", 16'h1, coil_b_fault_flag);
        chk("coil a", 16'h0, coil_a_fault_flag);
        chk("fault", 16'h1, electrical_fault_flag);
        st();
        chk("fault", 16'h0, electrical_fault_flag);
    endtask
    task automatic sk(input logic [15:0] p);
        cmd(9, {ab(0), 8'h88, 16'hffff, 8'h11, p, 16'h0400});
    endtask
    task automatic t_seek();
        @(posedge clk_sys);
        actual_position <= 16'h0100;
        sk(16'h0200);
        chk("seek", 16'h8, seen);
        @(posedge clk_sys);
        seek_second_done <= 1'h1;
        @(posedge clk_sys);
        seek_second_done <= 1'h0;
        grab();
        chk("position clear", 16'h4, seen);
        sk(16'h0100);
        chk("deadlock", 16'h1, deadlock_state);
        mv(16'h0777);
        chk("move in deadlock", 16'h0, seen[6]);
        st();
        chk("deadlock kept", 16'h1, deadlock_state);
        cmd(2, {ab(0), 8'h85});
        st();
        chk("deadlock left", 16'h0, deadlock_state);
    endtask
    task automatic t_otp();
        cmd(6, {ab(0), 8'h90, 16'hffff, 8'hfa, 8'h05});
        chk("otp pulse", 16'h2, seen);
        chk("otp index", 16'h2, otp_byte_index);
        chk("otp pattern", 16'h5, otp_pattern);
        chk("node", 16'h5, fused_node_address);
        mv(16'h0abc);
        chk("old node", 16'h1, seen);
        node = 4'h5;
        @(posedge clk_sys);
        hardwired_address_pin <= 1'h1;
        cmd(6, {ab(1), 8'h8b, 16'hffff, 16'h0abc});
        chk("new node", 16'h0abc, target_position);
        @(posedge clk_sys);
        switch_input <= 1'h1;
        grab();
        chk("switch idle", 16'h0, seen);
        chk("switch flag", 16'h1, switch_status_flag);
    endtask
    // Reset, then the scenarios in order; fuses last as they persist
    initial
    begin
        rst_n = 1'h0;
        node = 4'h0;
        {hardwired_address_pin, thermal_shutdown_flag, undervoltage_flag,
            lost_step_flag, coil_a_overcurrent, coil_a_open_load,
            coil_b_overcurrent, coil_b_open_load, seek_second_done,
            switch_input, step_resolution, actual_position} = 28'h0;
        repeat (5) @(posedge clk_sys);
        rst_n <= 1'h1;
        @(negedge clk_sys);
        chk("shutdown", 16'h1, shutdown_state);
        chk("node", 16'h0, fused_node_address);
        t_gate();
        t_move();
        t_refuse();
        t_halt();
        t_coil();
        t_seek();
        t_otp();
        report_and_stop();
    end
    // Hang guard
    initial
    begin
        #2000000;
        bad_count++;
        report_and_stop();
    end
endmodule
